// file: hw/som_defines.svh
`ifndef SOM_DEFINES_SVH
`define SOM_DEFINES_SVH

// ----------------------------------------
// Clock and reset delay timing
// ----------------------------------------
`define SOM_CLK_PERIOD_NS 10
`define SOM_RESET_DELAY_ONE_NS 10000
`define SOM_RESET_DELAY_TWO_NS 2000
`define SOM_RESET_DELAY_ONE_CYC \
  ((`SOM_RESET_DELAY_ONE_NS + `SOM_CLK_PERIOD_NS - 1) / `SOM_CLK_PERIOD_NS)
`define SOM_RESET_DELAY_TWO_CYC \
  ((`SOM_RESET_DELAY_TWO_NS + `SOM_CLK_PERIOD_NS - 1) / `SOM_CLK_PERIOD_NS)
`define SOM_TMR_W 12

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define SOM_FRAME_BITS 16
`define SOM_FRM_WR_BIT 15
`define SOM_FRM_ADDR_HI 14
`define SOM_FRM_ADDR_LO 8
`define SOM_ADDR_MODE_CTRL 7'h01
`define SOM_ADDR_WAKE_CTRL 7'h02

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SOM_MODE_HI 7
`define SOM_MODE_LO 6
`define SOM_AUX_REQ_BIT 5
`define SOM_WAKE_EN_HI 2
`define SOM_LOCK_BIT 7
`define SOM_MODE_NORMAL 2'h0
`define SOM_MODE_SLEEP 2'h1
`define SOM_MODE_STOP 2'h2
`define SOM_MODE_SOFT_RST 2'h3
`define SOM_WAKE_EN_RST 3'h7

`endif

// file: hw/som_delay_timer.sv
`timescale 1ns/1ps
module som_delay_timer import som_pkg::*; #(
  parameter int LEN_ONE = `SOM_RESET_DELAY_ONE_CYC,
  parameter int LEN_TWO = `SOM_RESET_DELAY_TWO_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic sel_two,
  output logic done
);
  som_tmr_t q_q, d_d;
  logic [`SOM_TMR_W-1:0] last;

  // ----------------------------------------
  // Counter: restarts whenever run drops
  // ----------------------------------------
  always_comb begin
    d_d = q_q;
    last = sel_two ? `SOM_TMR_W'(LEN_TWO - 1) : `SOM_TMR_W'(LEN_ONE - 1);
    if (!run) begin
      d_d.cnt = '0;
      d_d.done = 1'b0;
    end else if (q_q.cnt >= last) begin
      d_d.done = 1'b1;
    end else begin
      d_d.cnt = q_q.cnt + `SOM_TMR_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q_q <= '{cnt: '0, done: 1'b0};
    end else begin
      q_q <= d_d;
    end
  end

  assign done = q_q.done;

  property p_done_needs_run;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(done) |-> $past(run);
  endproperty
  a_done_needs_run: assert property (p_done_needs_run) else $error("done without run");
endmodule

// file: hw/som_mode_fsm.sv
`timescale 1ns/1ps
module som_mode_fsm import som_pkg::*; #(
  parameter int LEN_ONE = `SOM_RESET_DELAY_ONE_CYC,
  parameter int LEN_TWO = `SOM_RESET_DELAY_TWO_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial control pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Straps sampled in Init
  input wire logic dev_strap,
  input wire logic cfg_failsafe_strap,
  // Fault inputs
  input wire logic wd_fail,
  input wire logic main_uv,
  input wire logic overtemp,
  // Wake inputs
  input wire logic can_wake,
  input wire logic hv_wake_input,
  input wire logic gpio_wake,
  // Supply and peripheral controls
  output logic main_supply_en,
  output logic aux_supply_en,
  output logic can_normal_force,
  output logic mcu_reset_n,
  output logic wd_run,
  // Mode status
  output som_state_t mode_state,
  output logic dev_active
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  som_core_t q_q, d_d; // Mode machine state and next value
  logic frame_valid; // One-cycle pulse per good frame
  logic [15:0] frame_data; // Received frame
  logic [15:0] tx_word; // Status word returned on next frame
  logic tmr_done; // Reset delay elapsed
  logic wr_mode; // Write to mode control register
  logic wr_wake; // Write to wake control register
  logic [1:0] cmd_mode; // Requested mode
  logic wake_any; // Any enabled wake source
  logic wd_fail_v; // Watchdog failure that counts
  logic fault_now; // Failure that blocks Restart exit

  // Frame decoder used for both registers
  function automatic logic is_write(input logic [15:0] f, input logic [6:0] a);
    return f[`SOM_FRM_WR_BIT] && (f[`SOM_FRM_ADDR_HI:`SOM_FRM_ADDR_LO] == a);
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  som_spi_frame u_spi (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .tx_word(tx_word),
    .frame_valid(frame_valid),
    .frame_data(frame_data)
  );

  som_delay_timer #(
    .LEN_ONE(LEN_ONE),
    .LEN_TWO(LEN_TWO)
  ) u_tmr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(q_q.tmr_run),
    .sel_two(q_q.delay_sel),
    .done(tmr_done)
  );

  // ----------------------------------------
  // Decode and event terms
  // ----------------------------------------
  assign wr_mode = frame_valid && is_write(frame_data, `SOM_ADDR_MODE_CTRL);
  assign wr_wake = frame_valid && is_write(frame_data, `SOM_ADDR_WAKE_CTRL);
  assign cmd_mode = frame_data[`SOM_MODE_HI:`SOM_MODE_LO];
  assign wake_any = (can_wake && q_q.wake_en[0]) || (hv_wake_input && q_q.wake_en[1])
                    || (gpio_wake && q_q.wake_en[2]);
  assign wd_fail_v = wd_fail && !q_q.dev;
  assign fault_now = main_uv || wd_fail_v;
  // Status answer: mode field, aux request, flags, wake enables
  assign tx_word = {8'h00, q_q.mode_field, q_q.aux_req, q_q.dev, q_q.cfg_fs, q_q.wake_en};

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  always_comb begin
    d_d = q_q;
    // Register writes from the microcontroller
    if (wr_mode && !(q_q.st inside {ST_RESTART, ST_FAILSAFE, ST_SLEEP})) begin
      d_d.mode_field = cmd_mode;
      d_d.aux_req = frame_data[`SOM_AUX_REQ_BIT];
    end
    if (wr_wake && !q_q.lock) begin
      d_d.wake_en = frame_data[`SOM_WAKE_EN_HI:0];
      d_d.lock = frame_data[`SOM_LOCK_BIT];
    end
    case (q_q.st)
      ST_INIT: begin
        // Straps caught while in Init
        d_d.dev = dev_strap;
        d_d.cfg_fs = cfg_failsafe_strap;
        if (main_uv || wd_fail_v) begin
          d_d.st = ST_RESTART;
          d_d.delay_sel = 1'b0;
        end else if (frame_valid) begin
          // Any good frame moves on; wakes are ignored here
          d_d.st = ST_NORMAL;
        end
      end
      ST_NORMAL, ST_STOP: begin
        if (overtemp) begin
          d_d.st = ST_FAILSAFE;
          d_d.ot_seen = 1'b1;
        end else if (main_uv) begin
          d_d.st = ST_RESTART;
          d_d.delay_sel = 1'b0;
        end else if (wd_fail_v) begin
          d_d.st = q_q.cfg_fs ? ST_FAILSAFE : ST_RESTART;
          d_d.delay_sel = 1'b0;
        end else if (wr_mode) begin
          if (cmd_mode == `SOM_MODE_SOFT_RST) begin
            // Soft reset reloads everything not locked
            d_d.st = ST_INIT;
            d_d.mode_field = `SOM_MODE_NORMAL;
            d_d.aux_req = 1'b0;
            if (!q_q.lock) begin
              d_d.wake_en = `SOM_WAKE_EN_RST;
            end
          end else if (cmd_mode == `SOM_MODE_SLEEP) begin
            d_d.st = ST_SLEEP;
          end else if (cmd_mode == `SOM_MODE_STOP) begin
            d_d.st = ST_STOP;
          end else begin
            d_d.st = ST_NORMAL;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          d_d.st = ST_RESTART;
          d_d.delay_sel = 1'b1;
        end
      end
      ST_RESTART: begin
        // Leave for Normal only after the fault cleared and the delay ran out
        if (overtemp) begin
          d_d.st = ST_FAILSAFE;
          d_d.ot_seen = 1'b1;
        end else if (tmr_done && !fault_now) begin
          d_d.st = ST_NORMAL;
        end
      end
      ST_FAILSAFE: begin
        // Permanent until a wake or, after an overtemp entry, the heat goes away
        if (wake_any || (q_q.ot_seen && !overtemp)) begin
          d_d.st = ST_RESTART;
          d_d.delay_sel = 1'b1;
          d_d.ot_seen = 1'b0;
        end
      end
      default: begin
        d_d.st = ST_INIT;
      end
    endcase
    // Mode field reads back Normal as soon as Restart is entered
    if (d_d.st == ST_RESTART) begin
      d_d.mode_field = `SOM_MODE_NORMAL;
    end
    // Outputs follow the next mode so they leave flops in step with it
    d_d.tmr_run = (d_d.st == ST_RESTART) && (q_q.st == ST_RESTART) && !fault_now;
    d_d.main_en = !(d_d.st inside {ST_SLEEP, ST_FAILSAFE});
    d_d.aux_en = d_d.dev || d_d.aux_req;
    d_d.can_force = d_d.dev;
    d_d.mcu_rst_n = !(d_d.st inside {ST_RESTART, ST_FAILSAFE, ST_SLEEP});
    d_d.wd_run = !d_d.dev && (d_d.st inside {ST_INIT, ST_NORMAL, ST_STOP});
  end

  // State register; power-up lands in Init
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q_q <= '{st: ST_INIT, mode_field: 2'h0, aux_req: 1'b0, wake_en: 3'h7,
               lock: 1'b0, dev: 1'b0, cfg_fs: 1'b0, ot_seen: 1'b0, delay_sel: 1'b0,
               tmr_run: 1'b0, main_en: 1'b1, aux_en: 1'b0, can_force: 1'b0,
               mcu_rst_n: 1'b1, wd_run: 1'b1};
    end else begin
      q_q <= d_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign main_supply_en = q_q.main_en;
  assign aux_supply_en = q_q.aux_en;
  assign can_normal_force = q_q.can_force;
  assign mcu_reset_n = q_q.mcu_rst_n;
  assign wd_run = q_q.wd_run;
  assign mode_state = q_q.st;
  assign dev_active = q_q.dev;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_soft_cmd;
    q_q.st == ST_NORMAL && wr_mode && cmd_mode == 2'h3 && !overtemp && !main_uv && !wd_fail_v;
  endsequence
  property p_soft_init;
    s_soft_cmd |=> mode_state == ST_INIT && mcu_reset_n;
  endproperty
  a_soft_init: assert property (p_soft_init) else $error("soft reset missed Init");

  property p_stop_main;
    mode_state == ST_STOP |-> main_supply_en;
  endproperty
  a_stop_main: assert property (p_stop_main) else $error("main off in Stop");

  property p_sleep_main;
    mode_state == ST_SLEEP |-> !main_supply_en && !mcu_reset_n;
  endproperty
  a_sleep_main: assert property (p_sleep_main) else $error("main on in Sleep");

  sequence s_sleep_wake;
    mode_state == ST_SLEEP && wake_any;
  endsequence
  property p_sleep_wake;
    s_sleep_wake |=> mode_state == ST_RESTART && !mcu_reset_n && main_supply_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("wake missed Restart");

  property p_restart_exit;
    mode_state == ST_RESTART && tmr_done && !fault_now && !overtemp
      |=> mode_state == ST_NORMAL && mcu_reset_n;
  endproperty
  a_restart_exit: assert property (p_restart_exit) else $error("Restart exit wrong");

  property p_restart_hold;
    mode_state == ST_RESTART && fault_now && !overtemp |=> mode_state == ST_RESTART;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("Restart left early");

  property p_failsafe_off;
    $changed(mode_state) && mode_state == ST_FAILSAFE |-> !main_supply_en;
  endproperty
  a_failsafe_off: assert property (p_failsafe_off) else $error("main on in Fail-Safe");

  property p_failsafe_hold;
    mode_state == ST_FAILSAFE && !wake_any && !(q_q.ot_seen && !overtemp)
      |=> mode_state == ST_FAILSAFE;
  endproperty
  a_failsafe_hold: assert property (p_failsafe_hold) else $error("Fail-Safe left");

  property p_dev_wd;
    dev_active |-> !wd_run;
  endproperty
  a_dev_wd: assert property (p_dev_wd) else $error("watchdog runs in development");

  property p_dev_pins;
    dev_active |-> can_normal_force && aux_supply_en;
  endproperty
  a_dev_pins: assert property (p_dev_pins) else $error("development outputs wrong");

  property p_wd_cfg;
    mode_state == ST_NORMAL && wd_fail_v && !overtemp && !main_uv
      |=> mode_state == ($past(q_q.cfg_fs) ? ST_FAILSAFE : ST_RESTART);
  endproperty
  a_wd_cfg: assert property (p_wd_cfg) else $error("watchdog reaction wrong");

  property p_mode_clear;
    mode_state == ST_RESTART |-> q_q.mode_field == 2'h0;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode field kept");

  property p_dev_stable;
    mode_state != ST_INIT && $past(mode_state) != ST_INIT |-> $stable(dev_active);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("dev flag moved");
endmodule

// file: hw/som_pkg.sv
package som_pkg;
  `include "som_defines.svh"

  // ----------------------------------------
  // Operating modes, one-hot
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_INIT = 6'h01,
    ST_NORMAL = 6'h02,
    ST_STOP = 6'h04,
    ST_SLEEP = 6'h08,
    ST_RESTART = 6'h10,
    ST_FAILSAFE = 6'h20
  } som_state_t;

  // Core state of the mode machine
  typedef struct packed {
    som_state_t st;
    logic [1:0] mode_field;
    logic aux_req;
    logic [2:0] wake_en;
    logic lock;
    logic dev;
    logic cfg_fs;
    logic ot_seen;
    logic delay_sel;
    logic tmr_run;
    logic main_en;
    logic aux_en;
    logic can_force;
    logic mcu_rst_n;
    logic wd_run;
  } som_core_t;

  // Serial frame receiver state
  typedef struct packed {
    logic sck_p;
    logic cs_p;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [15:0] tx;
    logic miso;
    logic valid;
    logic [15:0] frame;
  } som_spi_t;

  // Reset delay timer state
  typedef struct packed {
    logic [`SOM_TMR_W-1:0] cnt;
    logic done;
  } som_tmr_t;
endpackage

// file: hw/som_spi_frame.sv
`timescale 1ns/1ps
module som_spi_frame import som_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Frame side
  input wire logic [15:0] tx_word,
  output logic frame_valid,
  output logic [15:0] frame_data
);
  som_spi_t q_q, d_d;

  // ----------------------------------------
  // Shift logic
  // ----------------------------------------
  always_comb begin
    d_d = q_q;
    d_d.sck_p = spi_sck;
    d_d.cs_p = spi_cs_n;
    d_d.valid = 1'b0;
    if (q_q.cs_p && !spi_cs_n) begin
      // Frame start: preload answer word
      d_d.cnt = 5'h00;
      d_d.miso = tx_word[15];
      d_d.tx = {tx_word[14:0], 1'b0};
    end else if (!spi_cs_n && spi_sck && !q_q.sck_p) begin
      // Rising edge: sample, count saturates above frame size
      d_d.sh = {q_q.sh[14:0], spi_mosi};
      if (q_q.cnt != 5'h1f) begin
        d_d.cnt = q_q.cnt + 5'h01;
      end
    end else if (!spi_cs_n && !spi_sck && q_q.sck_p) begin
      // Falling edge: next answer bit
      d_d.miso = q_q.tx[15];
      d_d.tx = {q_q.tx[14:0], 1'b0};
    end else if (!q_q.cs_p && spi_cs_n) begin
      // Frame end: only exact 16-bit frames count
      d_d.valid = (q_q.cnt == 5'(`SOM_FRAME_BITS));
      d_d.frame = q_q.sh;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q_q <= '{sck_p: 1'b0, cs_p: 1'b1, sh: 16'h0000, cnt: 5'h00, tx: 16'h0000,
               miso: 1'b0, valid: 1'b0, frame: 16'h0000};
    end else begin
      q_q <= d_d;
    end
  end

  assign spi_miso = q_q.miso;
  assign frame_valid = q_q.valid;
  assign frame_data = q_q.frame;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_frame_len;
    @(posedge clk_sys) disable iff (!nrst)
      frame_valid |-> $past(q_q.cnt) == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 16 bits");
endmodule

// file: verification/som_spi_master.sv
`timescale 1ns/1ps
// ----------------------------------------
// Microcontroller side: serial frame master
// ----------------------------------------
module som_spi_master (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Idle: deselected, clock parked low
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // One frame, MSB first; nbits below 16 makes a short frame
  task automatic xfer(input logic [15:0] word, input int nbits, input int half,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(negedge clk_sys);
    spi_cs_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (i = 0; i < nbits; i++) begin
      // Data set while the clock is low, held over the rise
      spi_mosi = word[15-i];
      repeat (half) @(negedge clk_sys);
      spi_sck = 1'b1;
      rx = {rx[14:0], spi_miso};
      repeat (half) @(negedge clk_sys);
      spi_sck = 1'b0;
    end
    repeat (half) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    // Released data line no longer shows the last bit
    spi_mosi = ~spi_mosi;
    // Gap between frames and time for the answer to land
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import som_pkg::*;
  // ----------------------------------------
  // Signals and bench model state
  // ----------------------------------------
  localparam int L1 = 12;
  localparam int L2 = 3;
  logic clk_sys, nrst, sck, cs_n, mosi, miso, dev_strap, cfg_fs;
  logic [5:0] ev; // gpio, hv, can, overtemp, uv, wd
  logic main_en, aux_en, can_force, mcu_rst_n, wd_on, dev_act;
  som_state_t mode_state;
  som_state_t exp_st;
  int mismatches, num_checks, exp_dev, exp_aux, n, k;
  logic [31:0] seed;
  logic [15:0] rx;

  som_mode_fsm #(.LEN_ONE(L1), .LEN_TWO(L2)) som_mode_fsm_inst (
    .clk_sys(clk_sys), .nrst(nrst), .spi_sck(sck), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .dev_strap(dev_strap),
    .cfg_failsafe_strap(cfg_fs), .wd_fail(ev[0]), .main_uv(ev[1]),
    .overtemp(ev[2]), .can_wake(ev[3]), .hv_wake_input(ev[4]),
    .gpio_wake(ev[5]), .main_supply_en(main_en), .aux_supply_en(aux_en),
    .can_normal_force(can_force), .mcu_reset_n(mcu_rst_n), .wd_run(wd_on),
    .mode_state(mode_state), .dev_active(dev_act));
  som_spi_master som_spi_master_inst (
    .clk_sys(clk_sys), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Compare every output except spi_miso with the model's view of the mode
  task automatic check_outs();
    logic off;
    logic up;
    off = (exp_st == ST_SLEEP) || (exp_st == ST_FAILSAFE);
    up = (exp_st == ST_INIT) || (exp_st == ST_NORMAL) || (exp_st == ST_STOP);
    chk(16'(mode_state), 16'(exp_st));
    chk(16'(main_en), 16'(!off));
    chk(16'(mcu_rst_n), 16'(!off && exp_st != ST_RESTART));
    chk(16'(wd_on), 16'(up && exp_dev == 0));
    chk(16'(aux_en), 16'(exp_dev | exp_aux));
    chk(16'(can_force), 16'(exp_dev));
    chk(16'(dev_act), 16'(exp_dev));
  endtask

  // Wait a bounded time for a mode, then compare all outputs but spi_miso
  task automatic go(input som_state_t t, input int lim);
    n = 0;
    while (mode_state !== t && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    exp_st = t;
    check_outs();
  endtask

  // Mode control write with a random serial clock rate
  task automatic wr_mode(input logic [1:0] m, input logic a);
    int h;
    h = int'(rnd() % 3) + 2;
    som_spi_master_inst.xfer({1'b1, 7'h01, m, a, 5'h00}, 16, h, rx);
  endtask

  task automatic pulse(input int i);
    ev[i] = 1'b1;
    @(negedge clk_sys);
    ev[i] = 1'b0;
  endtask

  // Restart must last its delay, then Normal follows
  task automatic restart_to_normal(input int len);
    go(ST_RESTART, 6);
    go(ST_NORMAL, len + 8);
    chk(16'(n >= len && n <= len + 6), 16'h0001);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    dev_strap = 1'b0;
    cfg_fs = 1'b0;
    ev = 6'h00;
    seed = 69;
    mismatches = 0;
    num_checks = 0;
    exp_dev = 0;
    exp_aux = 0;
    exp_st = ST_INIT;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    check_outs();
    wr_mode(2'h0, 1'b0);
    go(ST_NORMAL, 4);
    // Stop keeps the main rail, aux request random
    rx = 16'(rnd());
    exp_aux = int'(rx[0]);
    wr_mode(2'h2, rx[0]);
    go(ST_STOP, 4);
    exp_aux = 0;
    wr_mode(2'h0, 1'b0);
    go(ST_NORMAL, 4);
    // Sleep, a refused write, then each wake source
    for (k = 3; k < 6; k++) begin
      wr_mode(2'h1, 1'b0);
      go(ST_SLEEP, 4);
      wr_mode(2'h0, 1'b0);
      go(ST_SLEEP, 4);
      pulse(k);
      restart_to_normal(L2);
    end
    // Mode field reads back cleared after Restart
    som_spi_master_inst.xfer(16'h0100, 16, 2, rx);
    chk(rx, 16'h0007);
    // Undervoltage held, then released
    ev[1] = 1'b1;
    go(ST_RESTART, 6);
    repeat (2 * L1) @(negedge clk_sys);
    go(ST_RESTART, 0);
    ev[1] = 1'b0;
    go(ST_NORMAL, L1 + 8);
    chk(16'(n >= L1 && n <= L1 + 6), 16'h0001);
    pulse(0);
    restart_to_normal(L1);
    // Short frame is discarded
    som_spi_master_inst.xfer(16'h8180, 15, 2, rx);
    go(ST_NORMAL, 0);
    // Soft reset with Fail-Safe reaction strapped
    cfg_fs = 1'b1;
    wr_mode(2'h3, 1'b0);
    go(ST_INIT, 4);
    wr_mode(2'h0, 1'b0);
    go(ST_NORMAL, 4);
    pulse(0);
    go(ST_FAILSAFE, 6);
    repeat (20) @(negedge clk_sys);
    go(ST_FAILSAFE, 0);
    pulse(5);
    restart_to_normal(L2);
    ev[2] = 1'b1;
    go(ST_FAILSAFE, 6);
    repeat (20) @(negedge clk_sys);
    go(ST_FAILSAFE, 0);
    ev[2] = 1'b0;
    // Heat clearing leaves Fail-Safe like a wake, on the short delay
    restart_to_normal(L2);
    // Lock the wake enables with CAN wake off, then soft reset
    som_spi_master_inst.xfer(16'h8286, 16, 2, rx);
    // Development strap during Init
    dev_strap = 1'b1;
    wr_mode(2'h3, 1'b0);
    exp_dev = 1;
    go(ST_INIT, 4);
    // Any good frame leaves Init; answer shows locked enables and straps
    som_spi_master_inst.xfer(16'h0100, 16, 2, rx);
    chk(rx, 16'h001e);
    go(ST_NORMAL, 4);
    // Sleep still reachable; locked-off CAN wake is ignored there
    wr_mode(2'h1, 1'b0);
    go(ST_SLEEP, 4);
    pulse(3);
    repeat (2) @(negedge clk_sys);
    go(ST_SLEEP, 0);
    pulse(4);
    restart_to_normal(L2);
    pulse(0);
    repeat (6) @(negedge clk_sys);
    go(ST_NORMAL, 0);
    wr_mode(2'h2, 1'b0);
    go(ST_STOP, 4);
    // Reset in mid-run
    nrst = 1'b0;
    dev_strap = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    exp_dev = 0;
    go(ST_INIT, 0);
    summarize();
  end

  // Hang guard, well beyond the expected run length
  initial begin
    #600000;
    mismatches++;
    summarize();
  end
endmodule
